// file: rtl/drive_io_defs.svh
// Bit positions, image sizes and constants of the cyclic I/O images
`ifndef DRIVE_IO_DEFS_SVH
`define DRIVE_IO_DEFS_SVH

// Status byte 0 of the input image
`define ST_FAULT_BIT      0
`define ST_WARN_BIT       1
`define ST_FWD_BIT        2
`define ST_REV_BIT        3
`define ST_READY_BIT      4
`define ST_RUN_NET_BIT    5
`define ST_SPD_NET_BIT    6
`define ST_AT_REF_BIT     7

// Command byte 0 of the output image
`define CMD_FWD_BIT       0
`define CMD_REV_BIT       1
`define CMD_CLR_BIT       2
`define CMD_RUN_SEL_BIT   5
`define CMD_SPD_SEL_BIT   6

// Image lengths, expressed as the index of the last byte
`define OB_LAST_IDX       3'h5
`define TX_LAST_IDX       2'h3

// Output image byte indices of the staged fields
`define OB_SPD_LO_IDX     3'h2
`define OB_SPD_HI_IDX     3'h3
`define OB_TRQ_LO_IDX     3'h4

// Speed scaling selection
`define FREQ_MODE_HIGH    8'h02
`define POLES_NONE        8'h00
`define DIV10_MUL         32'h0000CCCD
`define DIV10_SHIFT       19

// Reset values
`define CMD_RESET         8'h00
`define WORD_RESET        16'h0000

`endif

// file: rtl/drive_io_pkg.sv
// Types shared by the I/O image packer and its status builder
package drive_io_pkg;

  // Drive state codes carried in input byte 1
  typedef enum logic [2:0] {
    ds_startup   = 3'h1,
    ds_not_ready = 3'h2,
    ds_ready     = 3'h3,
    ds_enabled   = 3'h4,
    ds_stopping  = 3'h5,
    ds_fault_stop = 3'h6,
    ds_faulted   = 3'h7
  } drive_state_t;

  // Input image transmitter states, Gray along idle -> send
  typedef enum logic [1:0] {
    tx_idle = 2'h0,
    tx_send = 2'h1
  } tx_state_t;

endpackage

// file: rtl/drive_io_if.sv
// Carrier between the packer and the status image builder
`timescale 1ns/1ns
interface drive_io_if;
  logic [7:0]  status_byte;  // Input image byte 0
  logic [2:0]  state_code;   // Input image byte 1, low bits
  logic [15:0] speed_word;   // Input image bytes 2 and 3
  logic        run_sel;      // Run command source is network
  logic        spd_sel;      // Speed reference source is network

  modport builder (
    input  run_sel,
    input  spd_sel,
    output status_byte,
    output state_code,
    output speed_word
  );
  modport packer (
    output run_sel,
    output spd_sel,
    input  status_byte,
    input  state_code,
    input  speed_word
  );
endinterface

// file: rtl/status_image_builder.sv
// Builds status flags, state code and scaled speed of the input image
`timescale 1ns/1ns
`include "drive_io_defs.svh"
module status_image_builder (
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  input  wire logic [5:0]  flag_pins,
  input  wire logic [2:0]  drive_state_code,
  input  wire logic [15:0] speed_centi_hz,
  input  wire logic [15:0] speed_rpm,
  input  wire logic [7:0]  motor_pole_setting,
  input  wire logic [7:0]  frequency_mode_setting,
  input  wire logic        product_variant,
  drive_io_if.builder      img
);

  // Divide by ten, exact for all 16-bit values
  function automatic logic [15:0] div10(input logic [15:0] v);
    logic [31:0] p;
    p = 32'(v) * `DIV10_MUL;
    p = p >> `DIV10_SHIFT;
    return p[15:0];
  endfunction

  logic [5:0]  s1_q, s2_q, s3_q; // Three-stage pin synchroniser
  logic [5:0]  flag_q, flag_d;   // Filtered flags
  logic [7:0]  stat_q, stat_d;   // Status byte
  logic [2:0]  code_q, code_d;   // State code
  logic [15:0] spd_q, spd_d;     // Scaled speed

  // A flag changes only when the second and third stages agree
  always_comb begin
    flag_d = flag_q;
    for (int i = 0; i < 6; i++) begin
      if (s2_q[i] == s3_q[i]) begin
        flag_d[i] = s3_q[i];
      end
    end
    // Pins: fault, warning, fwd, rev, ready, at reference
    stat_d = {flag_q[5], img.spd_sel, img.run_sel, flag_q[4],
              flag_q[3], flag_q[2], flag_q[1], flag_q[0]};
    code_d = drive_state_code;
    // Speed units follow the pole setting and product variant
    if (motor_pole_setting != `POLES_NONE) begin
      spd_d = speed_rpm;
    end else if (!product_variant &&
                 frequency_mode_setting == `FREQ_MODE_HIGH) begin
      spd_d = div10(speed_centi_hz);
    end else begin
      spd_d = speed_centi_hz;
    end
  end

  // Registers; status bits 0..4 follow flag order in stat_d
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      s1_q   <= 6'h00;
      s2_q   <= 6'h00;
      s3_q   <= 6'h00;
      flag_q <= 6'h00;
      stat_q <= 8'h00;
      code_q <= drive_io_pkg::ds_startup;
      spd_q  <= `WORD_RESET;
    end else begin
      s1_q   <= flag_pins;
      s2_q   <= s1_q;
      s3_q   <= s2_q;
      flag_q <= flag_d;
      stat_q <= stat_d;
      code_q <= code_d;
      spd_q  <= spd_d;
    end
  end

  assign img.status_byte = stat_q;
  assign img.state_code  = code_q;
  assign img.speed_word  = spd_q;

endmodule // status_image_builder

// file: rtl/drive_io_assembly_packer.sv
// Packs the input status image and unpacks the speed/torque output image
`timescale 1ns/1ns
`include "drive_io_defs.svh"
module drive_io_assembly_packer (
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  // Output image byte stream from the master
  input  wire logic        ob_valid,
  input  wire logic        ob_first,
  input  wire logic [7:0]  ob_data,
  // Input image byte stream to the master
  input  wire logic        tx_start,
  output logic             tx_valid,
  output logic             tx_last,
  output logic [7:0]       tx_data,
  // Drive status pins
  input  wire logic        drive_fault_pin,
  input  wire logic        drive_warning_pin,
  input  wire logic        drive_fwd_pin,
  input  wire logic        drive_rev_pin,
  input  wire logic        drive_ready_pin,
  input  wire logic        drive_at_ref_pin,
  // Drive values and settings on this clock
  input  wire logic [2:0]  drive_state_code,
  input  wire logic [15:0] speed_centi_hz,
  input  wire logic [15:0] speed_rpm,
  input  wire logic [7:0]  motor_pole_setting,
  input  wire logic [7:0]  frequency_mode_setting,
  input  wire logic        product_variant,
  // Locally configured sources
  input  wire logic        local_run_fwd,
  input  wire logic        local_run_rev,
  input  wire logic [15:0] local_speed_ref,
  // Commands to the drive
  output logic             run_fwd_out,
  output logic             run_rev_out,
  output logic             fault_clear_pulse,
  output logic             run_source_network,
  output logic             speed_source_network,
  output logic [15:0]      speed_ref_out,
  output logic [15:0]      torque_ref_pct
);

  drive_io_if img ();

  // Status image builder with its pin synchronisers
  status_image_builder u_status (
    .mclk                   (mclk),
    .sys_rst                (sys_rst),
    .flag_pins              ({drive_at_ref_pin, drive_ready_pin,
                              drive_rev_pin, drive_fwd_pin,
                              drive_warning_pin, drive_fault_pin}),
    .drive_state_code       (drive_state_code),
    .speed_centi_hz         (speed_centi_hz),
    .speed_rpm              (speed_rpm),
    .motor_pole_setting     (motor_pole_setting),
    .frequency_mode_setting (frequency_mode_setting),
    .product_variant        (product_variant),
    .img                    (img.builder)
  );

  // Output image receiver
  logic [2:0]  idx_q, idx_d;         // Next byte index in frame
  logic        in_frame_q, in_frame_d; // Frame in progress
  logic [7:0]  cmd_st_q, cmd_st_d;   // Staged command byte
  logic [7:0]  spd_lo_q, spd_lo_d;   // Staged speed low byte
  logic [7:0]  spd_hi_q, spd_hi_d;   // Staged speed high byte
  logic [7:0]  trq_lo_q, trq_lo_d;   // Staged torque low byte
  logic        commit;               // Last byte of a frame taken

  // Bytes are staged so a partial frame never reaches the drive
  always_comb begin
    idx_d      = idx_q;
    in_frame_d = in_frame_q;
    cmd_st_d   = cmd_st_q;
    spd_lo_d   = spd_lo_q;
    spd_hi_d   = spd_hi_q;
    trq_lo_d   = trq_lo_q;
    commit     = 1'b0;
    if (ob_valid && ob_first) begin
      // Byte 0 always opens a new frame
      cmd_st_d   = ob_data;
      idx_d      = 3'h1;
      in_frame_d = 1'b1;
    end else if (ob_valid && in_frame_q) begin
      // Byte 1 is unused and dropped
      case (idx_q)
        `OB_SPD_LO_IDX: spd_lo_d = ob_data;
        `OB_SPD_HI_IDX: spd_hi_d = ob_data;
        `OB_TRQ_LO_IDX: trq_lo_d = ob_data;
        default: begin
        end
      endcase
      if (idx_q == `OB_LAST_IDX) begin
        commit     = 1'b1;
        in_frame_d = 1'b0;
      end else begin
        idx_d = idx_q + 3'h1;
      end
    end
  end

  // Receiver registers
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      idx_q      <= 3'h0;
      in_frame_q <= 1'b0;
      cmd_st_q   <= `CMD_RESET;
      spd_lo_q   <= 8'h00;
      spd_hi_q   <= 8'h00;
      trq_lo_q   <= 8'h00;
    end else begin
      idx_q      <= idx_d;
      in_frame_q <= in_frame_d;
      cmd_st_q   <= cmd_st_d;
      spd_lo_q   <= spd_lo_d;
      spd_hi_q   <= spd_hi_d;
      trq_lo_q   <= trq_lo_d;
    end
  end

  logic [7:0]  net_cmd_q, net_cmd_d;   // Committed command byte
  logic [15:0] net_spd_q, net_spd_d;   // Committed speed reference
  logic [15:0] net_trq_q, net_trq_d;   // Committed torque reference
  logic        arm_fwd_q, arm_fwd_d;   // Forward seen low since reset or fault clear
  logic        arm_rev_q, arm_rev_d;   // Reverse seen low since reset or fault clear
  logic        arm_clr_q, arm_clr_d;   // Clear seen low since last use
  logic        clr_evt;                // Fault clear edge accepted
  logic        seen_q, seen_d;         // A frame has been committed
  logic [7:0]  cmd_low;                // Command bits known to be low
  logic        fwd_d, rev_d, clr_d;
  logic [15:0] sref_d, tref_d;

  // Arming flags turn a level into an edge: a bit only acts after it
  // has been seen low, so a command held high over a reset is inert
  always_comb begin
    net_cmd_d = net_cmd_q;
    net_spd_d = net_spd_q;
    net_trq_d = net_trq_q;
    if (commit) begin
      net_cmd_d = cmd_st_q;
      net_spd_d = {spd_hi_q, spd_lo_q};
      net_trq_d = {ob_data, trq_lo_q};
    end
    // The reset value is not a seen 0: only a committed frame arms
    seen_d  = seen_q | commit;
    cmd_low = seen_q ? ~net_cmd_q : 8'h00;
    clr_evt = net_cmd_q[`CMD_CLR_BIT] && arm_clr_q;
    arm_clr_d = arm_clr_q;
    if (clr_evt) begin
      arm_clr_d = 1'b0;
    end else if (cmd_low[`CMD_CLR_BIT]) begin
      arm_clr_d = 1'b1;
    end
    // A fault reset disarms the run commands once more
    arm_fwd_d = clr_evt ? 1'b0 :
                (cmd_low[`CMD_FWD_BIT] ? 1'b1 : arm_fwd_q);
    arm_rev_d = clr_evt ? 1'b0 :
                (cmd_low[`CMD_REV_BIT] ? 1'b1 : arm_rev_q);
    // Source selection per item
    if (net_cmd_q[`CMD_RUN_SEL_BIT]) begin
      fwd_d = net_cmd_q[`CMD_FWD_BIT] && arm_fwd_q && !clr_evt;
      rev_d = net_cmd_q[`CMD_REV_BIT] && arm_rev_q && !clr_evt;
    end else begin
      fwd_d = local_run_fwd;
      rev_d = local_run_rev;
    end
    sref_d = net_cmd_q[`CMD_SPD_SEL_BIT] ? net_spd_q
                                         : local_speed_ref;
    tref_d = net_trq_q;
    clr_d  = clr_evt;
  end

  // Decode registers and drive outputs
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      net_cmd_q            <= `CMD_RESET;
      net_spd_q            <= `WORD_RESET;
      net_trq_q            <= `WORD_RESET;
      arm_fwd_q            <= 1'b0;
      arm_rev_q            <= 1'b0;
      arm_clr_q            <= 1'b0;
      seen_q               <= 1'b0;
      run_fwd_out          <= 1'b0;
      run_rev_out          <= 1'b0;
      fault_clear_pulse    <= 1'b0;
      run_source_network   <= 1'b0;
      speed_source_network <= 1'b0;
      speed_ref_out        <= `WORD_RESET;
      torque_ref_pct       <= `WORD_RESET;
    end else begin
      net_cmd_q            <= net_cmd_d;
      net_spd_q            <= net_spd_d;
      net_trq_q            <= net_trq_d;
      arm_fwd_q            <= arm_fwd_d;
      arm_rev_q            <= arm_rev_d;
      arm_clr_q            <= arm_clr_d;
      seen_q               <= seen_d;
      run_fwd_out          <= fwd_d;
      run_rev_out          <= rev_d;
      fault_clear_pulse    <= clr_d;
      run_source_network   <= net_cmd_q[`CMD_RUN_SEL_BIT];
      speed_source_network <= net_cmd_q[`CMD_SPD_SEL_BIT];
      speed_ref_out        <= sref_d;
      torque_ref_pct       <= tref_d;
    end
  end

  // Selects reported back in the status byte
  assign img.run_sel = net_cmd_q[`CMD_RUN_SEL_BIT];
  assign img.spd_sel = net_cmd_q[`CMD_SPD_SEL_BIT];

  // Input image transmitter
  drive_io_pkg::tx_state_t tx_st_q, tx_st_d; // Transmitter state
  logic [1:0]  tx_idx_q, tx_idx_d;           // Byte being sent
  logic [31:0] snap_q, snap_d;               // Image snapshot
  logic        txv_d, txl_d;
  logic [7:0]  txb_d;
  logic [31:0] img_word;

  // Whole image is snapshotted so its four bytes stay consistent
  assign img_word = {img.speed_word, 5'h00, img.state_code,
                     img.status_byte};

  always_comb begin
    tx_st_d  = tx_st_q;
    tx_idx_d = tx_idx_q;
    snap_d   = snap_q;
    txv_d    = 1'b0;
    txl_d    = 1'b0;
    txb_d    = 8'h00;
    case (tx_st_q)
      drive_io_pkg::tx_idle: begin
        // A start while sending is ignored
        if (tx_start) begin
          snap_d   = img_word;
          tx_idx_d = 2'h0;
          tx_st_d  = drive_io_pkg::tx_send;
        end
      end
      drive_io_pkg::tx_send: begin
        txv_d = 1'b1;
        txb_d = snap_q[8*tx_idx_q +: 8];
        txl_d = (tx_idx_q == `TX_LAST_IDX);
        if (tx_idx_q == `TX_LAST_IDX) begin
          tx_st_d = drive_io_pkg::tx_idle;
        end else begin
          tx_idx_d = tx_idx_q + 2'h1;
        end
      end
      default: begin
        tx_st_d = drive_io_pkg::tx_idle;
      end
    endcase
  end

  // Transmitter registers
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      tx_st_q  <= drive_io_pkg::tx_idle;
      tx_idx_q <= 2'h0;
      snap_q   <= 32'h00000000;
      tx_valid <= 1'b0;
      tx_last  <= 1'b0;
      tx_data  <= 8'h00;
    end else begin
      tx_st_q  <= tx_st_d;
      tx_idx_q <= tx_idx_d;
      snap_q   <= snap_d;
      tx_valid <= txv_d;
      tx_last  <= txl_d;
      tx_data  <= txb_d;
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  tx_first_byte_a: assert property (
    (tx_start && tx_st_q == drive_io_pkg::tx_idle)
      |-> ##2 (tx_valid && tx_data == $past(img_word[7:0], 2)))
    else $error("first image byte is not the status byte");

  tx_burst_len_a: assert property (
    (tx_start && tx_st_q == drive_io_pkg::tx_idle)
      |-> ##2 (tx_valid && !tx_last) [*3] ##1 (tx_valid && tx_last)
          ##1 !tx_valid)
    else $error("input image is not four bytes");

  clr_one_cycle_a: assert property (
    fault_clear_pulse |=> !fault_clear_pulse)
    else $error("fault clear lasted more than one cycle");

  clr_cause_a: assert property (
    $rose(fault_clear_pulse) |-> $past(net_cmd_q[`CMD_CLR_BIT]))
    else $error("fault clear without a clear command");

  clr_disarm_a: assert property (
    clr_evt |=> (!arm_fwd_q && !arm_rev_q))
    else $error("run commands stay armed after fault reset");

  local_run_a: assert property (
    !net_cmd_q[`CMD_RUN_SEL_BIT] |=> run_fwd_out == $past(local_run_fwd))
    else $error("local run source not followed");

  net_speed_a: assert property (
    net_cmd_q[`CMD_SPD_SEL_BIT] |=> speed_ref_out == $past(net_spd_q))
    else $error("network speed reference not followed");

  cmd_decode_a: assert property (
    commit |-> ##2 run_source_network == $past(cmd_st_q[5], 2))
    else $error("run source select taken from wrong bit");

  torque_field_a: assert property (
    commit |-> ##3 torque_ref_pct == {$past(ob_data, 3),
                                      $past(trq_lo_q, 3)})
    else $error("torque reference not assembled low byte first");

endmodule // drive_io_assembly_packer

// file: tb/fieldbus_master_model.sv
// Master side model: sends output images and fetches input images
`timescale 1ns/1ns
module fieldbus_master_model (
  input  wire logic       mclk,
  output logic            ob_valid,
  output logic            ob_first,
  output logic [7:0]      ob_data,
  output logic            tx_start,
  input  wire logic       tx_valid,
  input  wire logic       tx_last,
  input  wire logic [7:0] tx_data
);
  // Bus idle from time zero
  initial begin
    ob_valid = 1'b0;
    ob_first = 1'b0;
    ob_data  = 8'h00;
    tx_start = 1'b0;
  end

  // One six-byte output image, low byte first, back to back
  task automatic send_frame(input logic [7:0] cmd, input logic [7:0] pad,
                            input logic [15:0] spd, input logic [15:0] trq);
    logic [7:0] b [6];
    b = '{cmd, pad, spd[7:0], spd[15:8], trq[7:0], trq[15:8]};
    for (int i = 0; i < 6; i++) begin
      @(posedge mclk) #2;
      ob_valid = 1'b1;
      ob_first = (i == 0);
      ob_data  = b[i];
    end
    @(posedge mclk) #2;
    ob_valid = 1'b0;
    ob_first = 1'b0;
    // Released lane flips so a stale byte never looks valid
    ob_data  = ~ob_data;
  endtask

  // Requests the input image; bytes must come in consecutive cycles
  task automatic read_image(output logic [31:0] img, output logic ok);
    int k;
    int g;
    k = 0;
    g = 0;
    img = 32'h0;
    ok = 1'b1;
    @(posedge mclk) #2;
    tx_start = 1'b1;
    @(posedge mclk) #2;
    tx_start = 1'b0;
    // Bounded wait so a silent design cannot hang the run
    while (k < 4 && g < 12) begin
      // Look after the edge, once the launched byte has settled
      @(posedge mclk) #2;
      g++;
      if (tx_valid === 1'b1) begin
        img[8*k +: 8] = tx_data;
        ok &= (tx_last === (k == 3));
        k++;
      end else if (k > 0) begin
        ok = 1'b0;
      end
    end
    if (k < 4) ok = 1'b0;
  endtask
endmodule // fieldbus_master_model

// file: tb/test_drive_io_assembly_packer.sv
// Self-checking bench for the I/O image packer
`timescale 1ns/1ns
module test_drive_io_assembly_packer;
  logic        mclk, sys_rst, ob_valid, ob_first, tx_start;
  logic        tx_valid, tx_last, product_variant;
  logic [7:0]  ob_data, tx_data, motor_pole_setting, frequency_mode_setting;
  logic        drive_fault_pin, drive_warning_pin, drive_fwd_pin;
  logic        drive_rev_pin, drive_ready_pin, drive_at_ref_pin;
  logic [2:0]  drive_state_code;
  logic [15:0] speed_centi_hz, speed_rpm, local_speed_ref;
  logic        local_run_fwd, local_run_rev, run_fwd_out, run_rev_out;
  logic        fault_clear_pulse, run_source_network, speed_source_network;
  logic [15:0] speed_ref_out, torque_ref_pct;
  logic [31:0] img;      // Last fetched input image
  logic        last_ok;  // Framing of the last fetch
  int          error_cnt, tests_run, pulse_cnt;

  drive_io_assembly_packer u_dut (.mclk, .sys_rst, .ob_valid, .ob_first,
    .ob_data, .tx_start, .tx_valid, .tx_last, .tx_data, .drive_fault_pin,
    .drive_warning_pin, .drive_fwd_pin, .drive_rev_pin, .drive_ready_pin,
    .drive_at_ref_pin, .drive_state_code, .speed_centi_hz, .speed_rpm,
    .motor_pole_setting, .frequency_mode_setting, .product_variant,
    .local_run_fwd, .local_run_rev, .local_speed_ref, .run_fwd_out,
    .run_rev_out, .fault_clear_pulse, .run_source_network,
    .speed_source_network, .speed_ref_out, .torque_ref_pct);

  fieldbus_master_model u_master (.mclk, .ob_valid, .ob_first, .ob_data,
    .tx_start, .tx_valid, .tx_last, .tx_data);

  // 20 MHz clock
  always #25 mclk = ~mclk;

  // Counts clear pulse cycles, so a stretched pulse shows as extra
  always @(posedge mclk) if (fault_clear_pulse === 1'b1) pulse_cnt++;

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #2;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                       input string what);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t %s got %h want %h", $time, what, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("errors %0d checks %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Pins in order fault, warning, fwd, rev, ready, at reference
  task automatic set_pins(input logic [5:0] p);
    {drive_at_ref_pin, drive_ready_pin, drive_rev_pin} = p[5:3];
    {drive_fwd_pin, drive_warning_pin, drive_fault_pin} = p[2:0];
  endtask

  // Standard frame with fixed references; waits past the commit
  task automatic frame(input logic [7:0] cmd);
    u_master.send_frame(cmd, 8'h00, 16'h1234, 16'hFF38);
    tick(5);
  endtask

  task automatic t_reset();
    check({run_fwd_out, run_rev_out, fault_clear_pulse, run_source_network,
           speed_source_network}, 0, "reset cmds");
    check({speed_ref_out, torque_ref_pct}, 0, "reset refs");
  endtask

  // Forward already high in the first frame must not start the motor
  task automatic t_power_on();
    frame(8'h61);
    check(run_fwd_out, 0, "run at power on");
  endtask

  // One flag at a time, then none; state code walks 1..7
  task automatic t_status();
    logic [5:0]  p;
    logic [31:0] ex;
    for (int i = 0; i < 7; i++) begin
      p = (i < 6) ? 6'(1 << i) : 6'h00;
      set_pins(p);
      drive_state_code = 3'(i + 1);
      tick(8);
      u_master.read_image(img, last_ok);
      // Both selects stay at network since the power-on frame
      ex = {16'h0ABC, 5'h00, 3'(i + 1), p[5], 2'b11, p[4:0]};
      check(last_ok, 1, "image framing");
      check(img, ex, "status image");
    end
  endtask

  // Unit selection: poles set, variant one both modes, variant two
  task automatic t_speed();
    logic [7:0]  pl [4] = '{8'h04, 8'h00, 8'h00, 8'h00};
    logic        vr [4] = '{1'b0, 1'b0, 1'b0, 1'b1};
    logic [7:0]  md [4] = '{8'h02, 8'h02, 8'h01, 8'h02};
    logic [15:0] ex [4] = '{16'h0ABC, 16'h04D2, 16'h3039, 16'h3039};
    for (int i = 0; i < 4; i++) begin
      motor_pole_setting = pl[i];
      product_variant = vr[i];
      frequency_mode_setting = md[i];
      tick(4);
      u_master.read_image(img, last_ok);
      check(img[31:16], ex[i], "speed scale");
    end
  endtask

  // Network references, then ignored command bits and padding byte
  task automatic t_net();
    frame(8'h60);
    check({run_source_network, speed_source_network}, 3, "sel");
    check(speed_ref_out, 16'h1234, "net speed");
    check(torque_ref_pct, 16'hFF38, "torque");
    u_master.read_image(img, last_ok);
    check(img[6:5], 2'b11, "source flags");
    u_master.send_frame(8'hF8, 8'hFF, 16'h0102, 16'h0000);
    tick(5);
    check({run_fwd_out, run_rev_out, run_source_network,
           speed_source_network}, 4'h3, "spare bits");
    check(speed_ref_out, 16'h0102, "speed after spare");
  endtask

  task automatic t_run();
    frame(8'h61);
    check({run_fwd_out, run_rev_out}, 2'b10, "fwd");
    frame(8'h62);
    check({run_fwd_out, run_rev_out}, 2'b01, "rev");
    frame(8'h60);
    check({run_fwd_out, run_rev_out}, 2'b00, "stop");
  endtask

  // Clear acts on a rising edge only and disarms held run commands
  task automatic t_fault();
    int base;
    frame(8'h61);
    base = pulse_cnt;
    frame(8'h65);
    check(pulse_cnt - base, 1, "clear edge");
    check(run_fwd_out, 0, "fwd held over clear");
    frame(8'h65);
    check(pulse_cnt - base, 1, "clear level");
    check(run_fwd_out, 0, "fwd still held");
    frame(8'h60);
    frame(8'h64);
    check(pulse_cnt - base, 2, "clear again");
    frame(8'h61);
    check(run_fwd_out, 1, "fresh fwd edge");
  endtask

  task automatic t_local();
    frame(8'h00);
    local_speed_ref = 16'hABCD;
    local_run_rev = 1'b1;
    tick(4);
    check(speed_ref_out, 16'hABCD, "local speed");
    check({run_fwd_out, run_rev_out, run_source_network,
           speed_source_network}, 4'h4, "local run");
  endtask

  // Watchdog: the whole sequence needs well under 1500 cycles
  initial begin
    #(3000 * 50);
    error_cnt++;
    close_out();
  end

  initial begin
    mclk = 1'b0;
    sys_rst = 1'b1;
    set_pins(6'h00);
    drive_state_code = 3'h3;
    speed_centi_hz = 16'h3039;
    speed_rpm = 16'h0ABC;
    motor_pole_setting = 8'h04;
    frequency_mode_setting = 8'h01;
    product_variant = 1'b0;
    local_run_fwd = 1'b0;
    local_run_rev = 1'b0;
    local_speed_ref = 16'h0000;
    error_cnt = 0;
    tests_run = 0;
    tick(10);
    sys_rst = 1'b0;
    t_reset();
    t_power_on();
    t_status();
    t_speed();
    t_net();
    t_run();
    t_fault();
    t_local();
    close_out();
  end
endmodule // test_drive_io_assembly_packer
